/* File: hdl/ipm_params.svh */
`ifndef IPM_PARAMS_SVH
`define IPM_PARAMS_SVH

// Register byte offsets
`define IPM_OFS_CTRL      12'h000
`define IPM_OFS_STATUS    12'h004
`define IPM_OFS_WAKE_IRQ  12'h008
`define IPM_OFS_WAKE_DRQ  12'h00C

// Control register fields
`define IPM_CTRL_DISK_LSB  0
`define IPM_CTRL_GLOB_LSB  4
`define IPM_CTRL_DISK_EN   8
`define IPM_CTRL_GLOB_EN   9
`define IPM_CTRL_RESET     12'hFFF

// Reset values of wake enables
`define IPM_WAKE_IRQ_RESET 16'hFFFF
`define IPM_WAKE_DRQ_RESET 8'hFF

// Timing
`define IPM_CLK_HZ         25000000
`define IPM_MINUTE_S       60
`define IPM_BLINK_MS       1600
`define IPM_MINUTE_CYC     (`IPM_CLK_HZ * `IPM_MINUTE_S)
`define IPM_HALF_BLINK_CYC (`IPM_CLK_HZ / 1000 * `IPM_BLINK_MS / 2)

`endif

/* File: hdl/ipm_pkg.sv */
package ipm_pkg;
	typedef enum logic [1:0] {
		IPM_NORMAL  = 2'b00,
		IPM_DISK_SB = 2'b01,
		IPM_SUSPEND = 2'b11
	} ipm_state_t;
	typedef logic [3:0] ipm_minutes_t;
endpackage : ipm_pkg

/* File: hdl/ipm_idle_timer.sv */
`timescale 1ns/100ps
// Minute-grain idle count up to the limit; restarts on activity
module ipm_idle_timer (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  minuteTick,
	input  wire logic                  activity,
	input  wire logic                  enable,
	input  wire ipm_pkg::ipm_minutes_t limit,
	output logic                       expired
);
	import ipm_pkg::*;

	ipm_minutes_t elapsed;

	// Limit of 0 is treated as 1 minute
	always_ff @(posedge mclk) begin
		if (rst || activity || !enable) begin
			elapsed <= 4'h0;
			expired <= 1'b0;
		end else if (minuteTick && !expired) begin
			if (elapsed + 4'h1 >= limit) begin
				expired <= 1'b1;
			end
			elapsed <= elapsed + 4'h1;
		end
	end

	AST_RESTART: assert property (@(posedge mclk) disable iff (rst)
		activity |=> !expired) else $error("timer did not restart");
endmodule : ipm_idle_timer

/* File: hdl/ipm_power_ctrl.sv */
`timescale 1ns/100ps
`include "ipm_params.svh"
module ipm_power_ctrl #(
	parameter int unsigned MINUTE_CYC     = `IPM_MINUTE_CYC,
	parameter int unsigned HALF_BLINK_CYC = `IPM_HALF_BLINK_CYC
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic         haddrSel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic         hready,
	input  wire logic [31:0]  hwdata,
	output logic      [31:0]  hrdata,
	output logic              hreadyout,
	output logic              hresp,
	input  wire logic         diskAccessPin,
	input  wire logic         keyActPin,
	input  wire logic         mouseActPin,
	input  wire logic [15:0]  irqPin,
	input  wire logic [7:0]   drqPin,
	input  wire logic         hsyncIn,
	input  wire logic         vsyncIn,
	output logic              hsyncOut,
	output logic              vsyncOut,
	output logic              diskStandbyCmd,
	output logic              panelLed,
	output ipm_pkg::ipm_state_t powerState
);
	import ipm_pkg::*;

	// Two-stage synchronisers for the disk, key, mouse, irq and drq pins
	localparam int NIN = 27;
	logic [NIN-1:0] pinRaw;
	logic [NIN-1:0] syncA;
	logic [NIN-1:0] syncB;
	assign pinRaw = {drqPin, irqPin, mouseActPin, keyActPin, diskAccessPin};
	always_ff @(posedge mclk) begin
		if (rst) begin
			syncA <= '0;
			syncB <= '0;
		end else begin
			syncA <= pinRaw;
			syncB <= syncA;
		end
	end

	logic diskAct;
	logic keyAct;
	logic mouseAct;
	logic [15:0] irqAct;
	logic [7:0]  drqAct;
	assign diskAct  = syncB[0];
	assign keyAct   = syncB[1];
	assign mouseAct = syncB[2];
	assign irqAct   = syncB[18:3];
	assign drqAct   = syncB[26:19];

	// Registers
	logic [11:0] ctrl;
	logic [15:0] wakeIrq;
	logic [7:0]  wakeDrq;
	logic        wrPend;
	logic [11:0] wrAddr;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wrPend <= 1'b0;
			wrAddr <= 12'h000;
		end else if (hready) begin
			wrPend <= haddrSel && htrans[1] && hwrite;
			wrAddr <= haddr[11:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl    <= `IPM_CTRL_RESET;
			wakeIrq <= `IPM_WAKE_IRQ_RESET;
			wakeDrq <= `IPM_WAKE_DRQ_RESET;
		end else if (wrPend) begin
			unique case (wrAddr)
				`IPM_OFS_CTRL:     ctrl    <= hwdata[11:0];
				`IPM_OFS_WAKE_IRQ: wakeIrq <= hwdata[15:0];
				`IPM_OFS_WAKE_DRQ: wakeDrq <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	ipm_state_t state;
	logic diskExp;
	logic globExp;

	// Read data registered at the address phase; zero-wait answer
	always_ff @(posedge mclk) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && haddrSel && htrans[1] && !hwrite) begin
			unique case (haddr[11:0])
				`IPM_OFS_CTRL:     hrdata <= {20'h00000, ctrl};
				`IPM_OFS_STATUS:   hrdata <= {27'h0000000, globExp, diskExp,
					panelLed, state};
				`IPM_OFS_WAKE_IRQ: hrdata <= {16'h0000, wakeIrq};
				`IPM_OFS_WAKE_DRQ: hrdata <= {24'h000000, wakeDrq};
				default:           hrdata <= 32'h0000_0000;
			endcase
		end
	end
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Minute tick shared by both timers
	logic [31:0] minCnt;
	logic        minuteTick;
	always_ff @(posedge mclk) begin
		if (rst || minuteTick) begin
			minCnt <= 32'h0000_0000;
		end else begin
			minCnt <= minCnt + 32'h0000_0001;
		end
	end
	assign minuteTick = (minCnt == MINUTE_CYC - 1);

	logic anyAct;
	logic wakeAct;
	assign wakeAct = keyAct || mouseAct || |(irqAct & wakeIrq)
		|| |(drqAct & wakeDrq);
	assign anyAct  = wakeAct || diskAct;

	ipm_idle_timer diskTimer (
		.mclk       (mclk),
		.rst        (rst),
		.minuteTick (minuteTick),
		.activity   (diskAct),
		.enable     (ctrl[`IPM_CTRL_DISK_EN]),
		.limit      (ctrl[`IPM_CTRL_DISK_LSB +: 4]),
		.expired    (diskExp)
	);
	ipm_idle_timer globTimer (
		.mclk       (mclk),
		.rst        (rst),
		.minuteTick (minuteTick),
		.activity   (anyAct),
		.enable     (ctrl[`IPM_CTRL_GLOB_EN]),
		.limit      (ctrl[`IPM_CTRL_GLOB_LSB +: 4]),
		.expired    (globExp)
	);

	// Power state machine
	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= IPM_NORMAL;
		end else begin
			unique case (state)
				IPM_NORMAL: begin
					if (globExp && !anyAct) begin
						state <= IPM_SUSPEND;
					end else if (diskExp && !diskAct) begin
						state <= IPM_DISK_SB;
					end
				end
				IPM_DISK_SB: begin
					if (diskAct) begin
						state <= IPM_NORMAL;
					end else if (globExp && !anyAct) begin
						state <= IPM_SUSPEND;
					end
				end
				IPM_SUSPEND: begin
					// Disk access also counts as system activity
					if (anyAct) begin
						state <= IPM_NORMAL;
					end
				end
				default: state <= IPM_NORMAL;
			endcase
		end
	end
	assign powerState = state;

	// Blink counter; only runs in suspend so the phase starts fresh
	logic [31:0] blinkCnt;
	logic        blinkPhase;
	always_ff @(posedge mclk) begin
		if (rst || state != IPM_SUSPEND) begin
			blinkCnt   <= 32'h0000_0000;
			blinkPhase <= 1'b0;
		end else if (blinkCnt == HALF_BLINK_CYC - 1) begin
			blinkCnt   <= 32'h0000_0000;
			blinkPhase <= !blinkPhase;
		end else begin
			blinkCnt <= blinkCnt + 32'h0000_0001;
		end
	end

	// Combinational from state so wake takes effect with the state change
	assign diskStandbyCmd = (state != IPM_NORMAL);
	assign hsyncOut = (state == IPM_SUSPEND) ? 1'b0 : hsyncIn;
	assign vsyncOut = (state == IPM_SUSPEND) ? 1'b0 : vsyncIn;
	assign panelLed = (state == IPM_SUSPEND) ? blinkPhase : 1'b1;

	AST_DISK_WAKE: assert property (@(posedge mclk) disable iff (rst)
		(state == IPM_DISK_SB && diskAct) |=> state == IPM_NORMAL)
		else $error("disk access did not wake");
	AST_DISK_SB: assert property (@(posedge mclk) disable iff (rst)
		(state == IPM_NORMAL && diskExp && !anyAct && !globExp) |=> state == IPM_DISK_SB)
		else $error("disk standby not entered");
	AST_SUSP_DISK: assert property (@(posedge mclk) disable iff (rst)
		state == IPM_SUSPEND |-> diskStandbyCmd)
		else $error("disk not in standby in suspend");
	AST_SYNC_OFF: assert property (@(posedge mclk) disable iff (rst)
		state == IPM_SUSPEND |-> !hsyncOut && !vsyncOut)
		else $error("sync not blanked");
	AST_WAKE: assert property (@(posedge mclk) disable iff (rst)
		(state == IPM_SUSPEND && (keyAct || mouseAct)) |=> state == IPM_NORMAL)
		else $error("wake missed");
	AST_RESTORE: assert property (@(posedge mclk) disable iff (rst)
		state == IPM_NORMAL |-> panelLed && hsyncOut == hsyncIn && vsyncOut == vsyncIn)
		else $error("outputs not restored");
	AST_BLINK: assert property (@(posedge mclk) disable iff (rst)
		(state == IPM_SUSPEND && blinkCnt == HALF_BLINK_CYC - 1 && $stable(state))
		|=> state != IPM_SUSPEND || panelLed != $past(panelLed))
		else $error("indicator did not toggle");
	AST_SUSP_ENTRY: assert property (@(posedge mclk) disable iff (rst)
		(state == IPM_NORMAL && globExp && !anyAct) |=> state == IPM_SUSPEND)
		else $error("suspend not entered");
endmodule : ipm_power_ctrl

/* File: test/ipm_far_side.sv */
`timescale 1ns/100ps
// Video sync source and disk drive as seen from the controller
module ipm_far_side (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic accessReq,
	output logic      hsyncIn,
	output logic      vsyncIn,
	output logic      diskAccessPin
);
	logic [3:0] phase;
	always_ff @(posedge mclk) begin
		phase <= rst ? 4'h0 : phase + 4'h1;
		// Distinct rates so a swapped sync pair shows up
		hsyncIn <= phase[0];
		vsyncIn <= phase[2];
		diskAccessPin <= accessReq;
	end
endmodule : ipm_far_side

/* File: test/ipm_power_ctrl_test.sv */
`timescale 1ns/100ps
`include "ipm_params.svh"
module ipm_power_ctrl_test;
	import ipm_pkg::*;
	logic        mclk = 0, rst = 1, haddrSel = 0, hwrite = 0, hready, hresp, hreadyout;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0]  htrans = 0;
	logic [15:0] irqPin = 0;
	logic [7:0]  drqPin = 0;
	logic        keyActPin = 0, mouseActPin = 0, accessReq = 0, led0;
	logic        hsyncIn, vsyncIn, hsyncOut, vsyncOut, diskStandbyCmd, panelLed, diskAccessPin;
	ipm_state_t  powerState;
	int          miscompares = 0, total_checks = 0, n;

	assign hready = hreadyout;
	always #20 mclk = ~mclk;

	// Short minute and blink counts keep the run brief
	ipm_power_ctrl #(.MINUTE_CYC(20), .HALF_BLINK_CYC(4)) ipm_power_ctrl_inst (
		.mclk, .rst, .haddrSel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready, .hwdata,
		.hrdata, .hreadyout, .hresp, .diskAccessPin, .keyActPin, .mouseActPin, .irqPin,
		.drqPin, .hsyncIn, .vsyncIn, .hsyncOut, .vsyncOut, .diskStandbyCmd, .panelLed,
		.powerState);
	ipm_far_side ipm_far_side_inst (.mclk, .rst, .accessReq, .hsyncIn, .vsyncIn,
		.diskAccessPin);

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		haddrSel <= 1'b1;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		haddrSel <= 1'b0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task wait_state(input ipm_state_t s, input int lim);
		n = 0;
		while (powerState !== s && n < lim) begin
			@(posedge mclk);
			#1;
			n++;
		end
	endtask : wait_state

	task led_gap;
		led0 = panelLed;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (panelLed === led0 && n < 12);
	endtask : led_gap

	// Source 0 key, 1 mouse, 2 enabled irq, 3 drq, 4 masked irq, other values release all
	task set_pins(input int i);
		keyActPin <= (i == 0);
		mouseActPin <= (i == 1);
		irqPin <= (i == 2) ? 16'h0020 : (i == 4) ? 16'h0008 : 16'h0000;
		drqPin <= (i == 3) ? 8'h04 : 8'h00;
	endtask : set_pins

	initial begin
		repeat (5000) @(posedge mclk);
		miscompares++;
		stop_test;
	end

	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		bus(0, `IPM_OFS_CTRL, 0);
		check(rd, `IPM_CTRL_RESET);
		bus(0, `IPM_OFS_WAKE_IRQ, 0);
		check(rd, 32'h0000_FFFF);
		bus(0, `IPM_OFS_STATUS, 0);
		check(rd, 32'h0000_0004);
		check(hresp, 1'b0);
		bus(0, 32'h0000_0010, 0);
		check(rd, 32'h0);
		$display("reset test done");
		bus(1, `IPM_OFS_CTRL, 32'h0000_03F1);
		wait_state(IPM_DISK_SB, 60);
		check({powerState, diskStandbyCmd}, {IPM_DISK_SB, 1'b1});
		@(posedge mclk);
		accessReq <= 1'b1;
		// One flop in the drive model, two synchroniser stages and the state register
		repeat (4) @(posedge mclk);
		#1;
		check({powerState, diskStandbyCmd}, {IPM_NORMAL, 1'b0});
		@(posedge mclk);
		accessReq <= 1'b0;
		$display("disk test done");
		bus(1, `IPM_OFS_CTRL, 32'h0000_0220);
		for (int k = 0; k < 10; k++) begin
			set_pins(0);
			@(posedge mclk);
			set_pins(7);
			repeat (14) @(posedge mclk);
			check(powerState, IPM_NORMAL);
		end
		wait_state(IPM_SUSPEND, 80);
		check({powerState, diskStandbyCmd}, {IPM_SUSPEND, 1'b1});
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk);
			#1;
			check({hsyncOut, vsyncOut}, 2'b00);
		end
		led_gap;
		led_gap;
		check(n, 4);
		$display("suspend test done");
		@(posedge mclk);
		bus(1, `IPM_OFS_WAKE_IRQ, 32'h0000_FFF7);
		for (int i = 0; i < 5; i++) begin
			wait_state(IPM_SUSPEND, 80);
			@(posedge mclk);
			set_pins(i);
			repeat (3) @(posedge mclk);
			#1;
			check(powerState, (i == 4) ? IPM_SUSPEND : IPM_NORMAL);
			if (i < 4)
				check({hsyncOut, vsyncOut, panelLed}, {hsyncIn, vsyncIn, 1'b1});
			@(posedge mclk);
			set_pins(7);
		end
		$display("wake test done");
		stop_test;
	end
endmodule : ipm_power_ctrl_test
